//--- pkg/mob_pkg.sv
// mob_pkg.sv: offsets, field positions, reset values and sizes of the register bank
// assumes: compiled before every other file of the block
package mob_pkg;
    // register offsets seen by the core
    localparam logic [5:0] ADDR_INDIRECT = 6'h00;
    localparam logic [5:0] ADDR_TIMER = 6'h01;
    localparam logic [5:0] ADDR_PC = 6'h02;
    localparam logic [5:0] ADDR_STATUS = 6'h03;
    localparam logic [5:0] ADDR_RAM_PTR = 6'h04;
    localparam logic [5:0] ADDR_PORT5 = 6'h05;
    localparam logic [5:0] ADDR_PORT6 = 6'h06;
    localparam logic [5:0] ADDR_PORT7 = 6'h07;
    localparam logic [5:0] ADDR_PORT8 = 6'h08;
    localparam logic [5:0] ADDR_LCD_CTRL = 6'h09;
    localparam logic [5:0] ADDR_LCD_SEGMENT_ADDRESS = 6'h0a;
    localparam logic [5:0] ADDR_LCD_DATA = 6'h0b;
    localparam logic [5:0] ADDR_CNT_EN = 6'h0c;
    // status and lcd control field positions
    localparam int ST_PAGE_LO = 5;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_PWRDOWN = 3;
    localparam int LCD_BIAS_BIT = 7;
    localparam int LCD_DUTY_LO = 5;
    localparam int LCD_ON_BIT = 4;
    localparam int LCD_WAVE_BIT = 2;
    localparam int LCD_RATE_LO = 0;
    localparam logic [7:0] LCD_CTRL_MASK = 8'hf7;
    // pin vector layout: port 5 high nibble, port 6, port 7, port 8 low five
    localparam int P5_LO = 0;
    localparam int P6_LO = 4;
    localparam int P7_LO = 12;
    localparam int P8_LO = 20;
    localparam int PIN_COUNT = 25;
    // reset values
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] TP_POWER_UP = 2'h3;
    // sizes
    localparam int PC_W = 12;
    localparam int JUMP_W = 10;
    localparam int STACK_DEPTH = 8;
    localparam int SEG_COUNT = 32;
    // common slot length in ticks per rate code and duty (1/2,1/3,1/4); decimal 256/172/128 etc
    localparam logic [8:0] LCD_BASE [4][3] = '{
        '{9'h100, 9'h0ac, 9'h080}, '{9'h118, 9'h0bc, 9'h08c},
        '{9'h130, 9'h0cc, 9'h098}, '{9'h0e8, 9'h09c, 9'h074}};
endpackage

//--- pkg/mob_links.sv
// mob_links.sv: carriers between the register bank and its pc and lcd units
// assumes: both ends on core_clk
`timescale 1ns/1ns
`default_nettype none
interface mob_pc_if;
    logic jmp, call, ret, addAcc, movLow, step;
    logic [9:0] target;
    logic [7:0] acc;
    logic [1:0] page;
    logic [11:0] pc;
    modport core(output jmp, call, ret, addAcc, movLow, step, target, acc, page, input pc);
    modport unit(input jmp, call, ret, addAcc, movLow, step, target, acc, page, output pc);
endinterface

interface mob_lcd_if;
    logic [7:0] ctrl;
    logic [4:0] addr;
    logic wr, tick;
    logic [3:0] wrData, rdData;
    modport core(output ctrl, addr, wr, tick, wrData, input rdData);
    modport unit(input ctrl, addr, wr, tick, wrData, output rdData);
endinterface
`default_nettype wire

//--- design/mob_pc.sv
// mob_pc.sv: program counter with paged loads and return stack
// assumes: at most one pc command per cycle from the core
`timescale 1ns/1ns
`default_nettype none
module mob_pc #(
    parameter int STACK_DEPTH = mob_pkg::STACK_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset_n,
    mob_pc_if.unit link
);
    localparam int PTR_W = $clog2(STACK_DEPTH);
    logic [11:0] stackMem [STACK_DEPTH];
    logic [PTR_W-1:0] stackTop;
    logic [11:0] pc;
    logic [9:0] addSum;

    assign link.pc = pc;
    assign addSum = pc[9:0] + {2'h0, link.acc}; // carry ripples into bits 8 and 9

    ////////////////////////////////////////////////////////////////////////
    // counter update; page bits follow status on every load except a return, which restores the stacked page
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pc <= mob_pkg::PC_RESET;
        end else if (link.call || link.jmp) begin
            pc <= {link.page, link.target};
        end else if (link.ret) begin
            pc <= stackMem[stackTop];
        end else if (link.addAcc) begin
            pc <= {link.page, addSum};
        end else if (link.movLow) begin
            pc <= {link.page, pc[9:8], link.acc};
        end else if (link.step) begin
            pc <= pc + 12'h001;
        end
    end

    // circular stack: a ninth call silently overwrites the oldest entry
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            stackTop <= '0;
        end else if (link.call) begin
            stackTop <= stackTop + 1'b1;
            stackMem[stackTop + 1'b1] <= pc + 12'h001;
        end else if (link.ret) begin
            stackTop <= stackTop - 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- design/mob_lcd.sv
// mob_lcd.sv: display memory, frame timing and digital com/seg drive
// assumes: tick is a one-cycle pulse per sub-oscillator rising edge
`timescale 1ns/1ns
`default_nettype none
module mob_lcd (
    input wire logic core_clk,
    input wire logic reset_n,
    mob_lcd_if.unit link,
    output logic [3:0] comOut,
    output logic [31:0] segOut
);
    logic [3:0] dispMem [mob_pkg::SEG_COUNT];
    logic [8:0] tickCnt, base;
    logic [1:0] phase, dutyIdx, dutyLast;
    logic lcdOn, pol, frameOdd;
    logic [31:0] segNext;

    assign lcdOn = link.ctrl[mob_pkg::LCD_ON_BIT];
    // quarter duty whenever the upper select bit is set
    assign dutyIdx = link.ctrl[mob_pkg::LCD_DUTY_LO+1] ? 2'h2 : {1'b0, link.ctrl[mob_pkg::LCD_DUTY_LO]};
    assign dutyLast = dutyIdx + 2'h1;
    assign base = mob_pkg::LCD_BASE[link.ctrl[mob_pkg::LCD_RATE_LO +: 2]][dutyIdx];
    // A type flips inside each slot, B type flips once per frame
    assign pol = link.ctrl[mob_pkg::LCD_WAVE_BIT] ? frameOdd : (tickCnt >= (base >> 1));
    assign link.rdData = dispMem[link.addr];

    ////////////////////////////////////////////////////////////////////////
    // display memory written through the segment data register
    always_ff @(posedge core_clk) begin
        if (link.wr) begin
            dispMem[link.addr] <= link.wrData;
        end
    end

    // each common slot lasts base ticks, so a frame is base times duty
    always_ff @(posedge core_clk) begin
        if (!reset_n || !lcdOn) begin
            tickCnt <= 9'h000;
            phase <= 2'h0;
            frameOdd <= 1'b0;
        end else if (link.tick) begin
            if (tickCnt == base - 9'h001) begin
                tickCnt <= 9'h000;
                if (phase == dutyLast) begin
                    phase <= 2'h0;
                    frameOdd <= ~frameOdd;
                end else begin
                    phase <= phase + 2'h1;
                end
            end else begin
                tickCnt <= tickCnt + 9'h001;
            end
        end
    end

    // one segment line per memory entry, bit picked by the active common
    for (genvar s = 0; s < mob_pkg::SEG_COUNT; s++) begin : g_seg
        assign segNext[s] = dispMem[s][phase] ^ pol;
    end

    // outputs grounded while the panel is off
    always_ff @(posedge core_clk) begin
        if (!reset_n || !lcdOn) begin
            comOut <= 4'h0;
            segOut <= 32'h0000_0000;
        end else begin
            comOut <= (4'h1 << phase) ^ {4{pol}};
            segOut <= segNext;
        end
    end
endmodule
`default_nettype wire

//--- design/mob_register_bank.sv
// mob_register_bank.sv: low-address operational registers of the 8-bit core
// assumes: one register access per cycle; pins asynchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module mob_register_bank #(
    parameter int STACK_DEPTH = mob_pkg::STACK_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic powerUp,
    input wire logic [5:0] regAddr,
    input wire logic regWr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic extSel,
    output logic extWr,
    output logic [7:0] extAddr,
    input wire logic [7:0] extRdData,
    input wire logic jmpGo,
    input wire logic callGo,
    input wire logic retGo,
    input wire logic pcAddAcc,
    input wire logic pcStep,
    input wire logic [9:0] opTarget,
    output logic [11:0] pcValue,
    input wire logic flagWr,
    input wire logic [2:0] flagIn,
    input wire logic sleepExec,
    input wire logic wdtClearExec,
    input wire logic wdtTimeout,
    input wire logic timerExtSel,
    input wire logic timerPin,
    output logic timerWrap,
    input wire logic [24:0] pinDir,
    input wire logic [24:0] pinIn,
    output logic [24:0] pinOut,
    output logic [24:0] pinDriveN,
    output logic controlPageSelect,
    output logic [1:0] dataBankSelect,
    input wire logic subOscPin,
    output logic lcdBiasSel,
    output logic [3:0] comOut,
    output logic [31:0] segOut,
    output logic counterOneRun,
    output logic counterTwoRun,
    output logic highPulseTimerRun,
    output logic lowPulseTimerRun
);
    logic [5:0] effAddr;
    logic isLocal;
    logic [7:0] timerCount, ramPtr, lcdCtrl;
    logic [4:0] lcdAddr;
    logic [3:0] cntEn;
    logic [1:0] romPage;
    logic [2:0] aluFlags;
    logic timeOut, powerDown, ctrlPage, timerTick;
    logic [24:0] pinLatch, pinS1, pinS2, pinRd;
    logic tpS1, tpS2, tpS3, soS1, soS2, soS3;

    mob_pc_if pcLink();
    mob_lcd_if lcdLink();

    // write hit after pointer redirection; clocked use only, an assign would miss updates
    function automatic logic wrAt(input logic [5:0] a);
        return regWr && (effAddr == a);
    endfunction

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // address decode; offset zero has no storage and follows the pointer
    assign effAddr = (regAddr == mob_pkg::ADDR_INDIRECT) ? ramPtr[5:0] : regAddr;
    assign isLocal = (effAddr != mob_pkg::ADDR_INDIRECT) && (effAddr <= mob_pkg::ADDR_CNT_EN);
    assign extSel = !isLocal && (effAddr != mob_pkg::ADDR_INDIRECT);
    assign extWr = regWr && extSel;
    assign extAddr = {ramPtr[7:6], effAddr};
    assign dataBankSelect = ramPtr[7:6];

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pinS1 <= '0;
            pinS2 <= '0;
            {tpS1, tpS2, tpS3} <= 3'h0;
            {soS1, soS2, soS3} <= 3'h0;
        end else begin
            pinS1 <= pinIn;
            pinS2 <= pinS1;
            {tpS1, tpS2, tpS3} <= {timerPin, tpS1, tpS2};
            {soS1, soS2, soS3} <= {subOscPin, soS1, soS2};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer count: a software write beats the increment in the same cycle
    assign timerTick = timerExtSel ? (tpS2 && !tpS3) : 1'b1;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            timerCount <= mob_pkg::REG_RESET;
            timerWrap <= 1'b0;
        end else begin
            timerWrap <= 1'b0;
            if (wrAt(mob_pkg::ADDR_TIMER)) begin
                timerCount <= regWrData;
            end else if (timerTick) begin
                timerCount <= timerCount + 8'h01;
                timerWrap <= (timerCount == 8'hff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter unit
    assign pcLink.jmp = jmpGo;
    assign pcLink.call = callGo;
    assign pcLink.ret = retGo;
    assign pcLink.addAcc = pcAddAcc;
    assign pcLink.movLow = regWr && (effAddr == mob_pkg::ADDR_PC);
    assign pcLink.step = pcStep;
    assign pcLink.target = opTarget;
    assign pcLink.acc = regWrData;
    assign pcLink.page = romPage;
    assign pcValue = pcLink.pc;

    mob_pc #(.STACK_DEPTH(STACK_DEPTH)) u_pc (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .link(pcLink)
    );

    ////////////////////////////////////////////////////////////////////////
    // status: page and alu flags writable; the cause flags are hardware only.
    // the cause flags survive a pin reset so the wake cause stays readable
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            romPage <= 2'h0;
            aluFlags <= 3'h0;
            if (powerUp) begin
                {timeOut, powerDown} <= mob_pkg::TP_POWER_UP;
            end
        end else begin
            if (wrAt(mob_pkg::ADDR_STATUS)) begin
                romPage <= regWrData[mob_pkg::ST_PAGE_LO +: 2];
                aluFlags <= regWrData[2:0];
            end else if (flagWr) begin
                aluFlags <= flagIn;
            end
            if (sleepExec || wdtClearExec) begin
                timeOut <= 1'b1;
            end else if (wdtTimeout) begin
                timeOut <= 1'b0;
            end
            if (wdtClearExec) begin
                powerDown <= 1'b1;
            end else if (sleepExec) begin
                powerDown <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ram pointer and port 5 page bit
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ramPtr <= mob_pkg::REG_RESET;
            ctrlPage <= 1'b0;
        end else begin
            if (wrAt(mob_pkg::ADDR_RAM_PTR)) begin
                ramPtr <= regWrData;
            end
            if (wrAt(mob_pkg::ADDR_PORT5)) begin
                ctrlPage <= regWrData[0];
            end
        end
    end
    assign controlPageSelect = ctrlPage;

    ////////////////////////////////////////////////////////////////////////
    // port latches; a direction bit of 1 makes the pin an input
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pinLatch <= '0;
        end else begin
            if (wrAt(mob_pkg::ADDR_PORT5)) begin
                pinLatch[mob_pkg::P5_LO +: 4] <= regWrData[7:4];
            end
            if (wrAt(mob_pkg::ADDR_PORT6)) begin
                pinLatch[mob_pkg::P6_LO +: 8] <= regWrData;
            end
            if (wrAt(mob_pkg::ADDR_PORT7)) begin
                pinLatch[mob_pkg::P7_LO +: 8] <= regWrData;
            end
            if (wrAt(mob_pkg::ADDR_PORT8)) begin
                pinLatch[mob_pkg::P8_LO +: 5] <= regWrData[4:0];
            end
        end
    end
    assign pinOut = pinLatch;
    assign pinDriveN = pinDir;
    assign pinRd = (pinDir & pinS2) | (~pinDir & pinLatch);

    ////////////////////////////////////////////////////////////////////////
    // lcd control, segment address and counter enables
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lcdCtrl <= mob_pkg::REG_RESET;
            lcdAddr <= 5'h00;
            cntEn <= 4'h0;
        end else begin
            if (wrAt(mob_pkg::ADDR_LCD_CTRL)) begin
                lcdCtrl <= regWrData & mob_pkg::LCD_CTRL_MASK;
            end
            if (wrAt(mob_pkg::ADDR_LCD_SEGMENT_ADDRESS)) begin
                lcdAddr <= regWrData[4:0];
            end
            if (wrAt(mob_pkg::ADDR_CNT_EN)) begin
                cntEn <= regWrData[3:0];
            end
        end
    end
    assign lcdBiasSel = lcdCtrl[mob_pkg::LCD_BIAS_BIT];
    assign {lowPulseTimerRun, highPulseTimerRun, counterTwoRun, counterOneRun} = cntEn;

    assign lcdLink.ctrl = lcdCtrl;
    assign lcdLink.addr = lcdAddr;
    assign lcdLink.wr = regWr && (effAddr == mob_pkg::ADDR_LCD_DATA);
    assign lcdLink.wrData = regWrData[3:0];
    assign lcdLink.tick = soS2 && !soS3;

    mob_lcd u_lcd (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .link(lcdLink),
        .comOut(comOut),
        .segOut(segOut)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data registered one cycle after the address
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            regRdData <= mob_pkg::REG_RESET;
        end else begin
            case (effAddr)
                mob_pkg::ADDR_INDIRECT: regRdData <= 8'h00;
                mob_pkg::ADDR_TIMER: regRdData <= timerCount;
                mob_pkg::ADDR_PC: regRdData <= pcLink.pc[7:0];
                mob_pkg::ADDR_STATUS: regRdData <= {1'b0, romPage, timeOut, powerDown, aluFlags};
                mob_pkg::ADDR_RAM_PTR: regRdData <= ramPtr;
                mob_pkg::ADDR_PORT5: regRdData <= {pinRd[3:0], 3'h0, ctrlPage};
                mob_pkg::ADDR_PORT6: regRdData <= pinRd[11:4];
                mob_pkg::ADDR_PORT7: regRdData <= pinRd[19:12];
                mob_pkg::ADDR_PORT8: regRdData <= {3'h0, pinRd[24:20]};
                mob_pkg::ADDR_LCD_CTRL: regRdData <= lcdCtrl;
                mob_pkg::ADDR_LCD_SEGMENT_ADDRESS: regRdData <= {3'h0, lcdAddr};
                mob_pkg::ADDR_LCD_DATA: regRdData <= {4'h0, lcdLink.rdData};
                mob_pkg::ADDR_CNT_EN: regRdData <= {4'h0, cntEn};
                default: regRdData <= extRdData;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_pc_reset;
        $rose(reset_n) |-> pcValue == mob_pkg::PC_RESET;
    endproperty
    a_pc_reset: assert property (p_pc_reset) else $error("pc not zero after reset");

    property p_jump;
        jmpGo && !callGo |=> pcValue == {$past(romPage), $past(opTarget)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or page wrong");

    property p_call_ret;
        (callGo && !retGo) ##1 (retGo && !callGo) |=> pcValue == $past(pcValue, 2) + 12'h001;
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address wrong");

    property p_ret_page;
        retGo && !wrAt(mob_pkg::ADDR_STATUS) |=> romPage == $past(romPage);
    endproperty
    a_ret_page: assert property (p_ret_page) else $error("return changed page");

    property p_mov_low;
        wrAt(mob_pkg::ADDR_PC) && !jmpGo && !callGo && !retGo && !pcAddAcc |=>
            pcValue[9:8] == $past(pcValue[9:8]) && pcValue[7:0] == $past(regWrData);
    endproperty
    a_mov_low: assert property (p_mov_low) else $error("move to pc wrong");

    property p_timer_count;
        !timerExtSel && !wrAt(mob_pkg::ADDR_TIMER) |=> timerCount == $past(timerCount) + 8'h01;
    endproperty
    a_timer_count: assert property (p_timer_count) else $error("timer missed a cycle");

    property p_indirect;
        regWr && regAddr == mob_pkg::ADDR_INDIRECT && ramPtr[5:0] == mob_pkg::ADDR_TIMER
            |=> timerCount == $past(regWrData);
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect write lost");

    property p_sleep_flags;
        sleepExec && !wdtClearExec |=> timeOut && !powerDown;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_timeout_flag;
        wdtTimeout && !sleepExec && !wdtClearExec |=> !timeOut;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("timeout not cleared");

    property p_lcd_off;
        !lcdCtrl[mob_pkg::LCD_ON_BIT] ##1 !lcdCtrl[mob_pkg::LCD_ON_BIT] |->
            comOut == 4'h0 && segOut == 32'h0000_0000;
    endproperty
    a_lcd_off: assert property (p_lcd_off) else $error("lcd outputs not grounded");

    property p_unused_read;
        effAddr == mob_pkg::ADDR_PORT8 |=> regRdData[7:5] == 3'h0;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("unused bits read nonzero");

    property p_enables;
        wrAt(mob_pkg::ADDR_CNT_EN) |=> counterOneRun == $past(regWrData[0])
            && lowPulseTimerRun == $past(regWrData[3]);
    endproperty
    a_enables: assert property (p_enables) else $error("counter enable wrong");

    c_jump: cover property (jmpGo);
    c_call_ret: cover property (callGo ##[1:20] retGo);
    c_indirect: cover property (regWr && regAddr == mob_pkg::ADDR_INDIRECT);
    c_lcd_on: cover property ($rose(lcdCtrl[mob_pkg::LCD_ON_BIT]));
endmodule
`default_nettype wire

//--- sim/mob_ext_ram.sv
// mob_ext_ram.sv: data memory that answers accesses the bank hands outside
// assumes: reads are combinational, writes land on the rising edge
`timescale 1ns/1ns
`default_nettype none
module mob_ext_ram (
    input wire logic core_clk,
    input wire logic extWr,
    input wire logic [7:0] extAddr,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData
);
    logic [7:0] mem [256];
    // bank bits are part of the address, so banks never alias
    always_ff @(posedge core_clk) begin
        if (extWr) begin
            mem[extAddr] <= wrData;
        end
    end
    // unwritten cells read as a fixed pattern rather than a settled unknown
    assign rdData = (mem[extAddr] === 8'hxx) ? 8'h5a : mem[extAddr];
endmodule
`default_nettype wire

//--- sim/tb_mob_register_bank.sv
// tb_mob_register_bank.sv: directed register and pc sequences on the bank
// assumes: mob_pkg and mob_links compiled first; pins looped back
`timescale 1ns/1ns
`default_nettype none
module tb_mob_register_bank;
    logic core_clk = 0, reset_n = 0, powerUp = 1, regWr = 0, extSel, extWr, timerWrap, cps;
    logic subOsc = 0, tmrExt = 0, tmrPin = 0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWrData = 8'h00, cmd = 8'h00, regRdData, extAddr, extRdData, d;
    logic [9:0] opTarget = 10'h000;
    logic [11:0] pcValue;
    logic [24:0] pinDir = 25'h0000000, pinOut, pinDriveN;
    logic [1:0] dbs;
    logic [3:0] comOut, run;
    logic [31:0] segOut;
    logic lcdBiasSel;
    int error_cnt = 0, n_checks = 0;
    mob_register_bank mob_register_bank_i (.core_clk(core_clk), .reset_n(reset_n),
        .powerUp(powerUp), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
        .regRdData(regRdData), .extSel(extSel), .extWr(extWr), .extAddr(extAddr),
        .extRdData(extRdData), .jmpGo(cmd[0]), .callGo(cmd[1]), .retGo(cmd[2]),
        .pcAddAcc(cmd[3]), .pcStep(cmd[4]), .opTarget(opTarget), .pcValue(pcValue),
        .flagWr(1'b0), .flagIn(3'h0), .sleepExec(cmd[5]), .wdtClearExec(cmd[6]),
        .wdtTimeout(cmd[7]), .timerExtSel(tmrExt), .timerPin(tmrPin), .timerWrap(timerWrap),
        .pinDir(pinDir), .pinIn(pinOut), .pinOut(pinOut), .pinDriveN(pinDriveN),
        .controlPageSelect(cps), .dataBankSelect(dbs), .subOscPin(subOsc),
        .lcdBiasSel(lcdBiasSel), .comOut(comOut), .segOut(segOut),
        .counterOneRun(run[0]), .counterTwoRun(run[1]), .highPulseTimerRun(run[2]),
        .lowPulseTimerRun(run[3]));
    mob_ext_ram mob_ext_ram_i (.core_clk(core_clk), .extWr(extWr), .extAddr(extAddr),
        .wrData(regWrData), .rdData(extRdData));
    ////////////////////////////////////////////////////////////////////////////////
    // clock at 100 MHz
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // sub-oscillator runs free, one rising edge every two cycles
    initial begin
        forever @(posedge core_clk) subOsc <= ~subOsc;
    end
    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // write strobe stands for exactly one edge
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [5:0] a);
        @(posedge core_clk);
        regAddr <= a;
        @(posedge core_clk);
        #1 d = regRdData;
    endtask
    task automatic go(input int b, input logic [9:0] t, input logic [7:0] acc);
        @(posedge core_clk);
        cmd <= 8'h01 << b;
        opTarget <= t;
        regWrData <= acc;
        @(posedge core_clk);
        cmd <= 8'h00;
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000 error_cnt++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        powerUp <= 1'b0;
        #1 chk(pcValue, 12'h000);
        chk({comOut, segOut}, 36'h0);
        rd(6'h03);
        chk(d, 8'h18);
        wr(6'h03, 8'hff);
        rd(6'h03);
        chk(d, 8'h7f);
        wr(6'h03, 8'h20);
        go(5, 10'h000, 8'h00);
        rd(6'h03);
        chk(d, 8'h30);
        go(7, 10'h000, 8'h00);
        rd(6'h03);
        chk(d, 8'h20);
        go(6, 10'h000, 8'h00);
        rd(6'h03);
        chk(d, 8'h38);
        go(0, 10'h3ff, 8'h00);
        chk(pcValue, 12'h7ff);
        go(1, 10'h123, 8'h00);
        chk(pcValue, 12'h523);
        wr(6'h02, 8'h44);
        #1 chk(pcValue, 12'h544);
        wr(6'h03, 8'h60);
        go(2, 10'h000, 8'h00);
        chk(pcValue, 12'h800);
        go(3, 10'h000, 8'hff);
        chk(pcValue, 12'hcff);
        go(3, 10'h000, 8'h02);
        chk(pcValue, 12'hd01);
        wr(6'h04, 8'hc6);
        wr(6'h00, 8'ha5);
        #1 chk({dbs, pinOut[11:4]}, 10'h3a5);
        wr(6'h04, 8'h50);
        wr(6'h00, 8'h3c);
        rd(6'h00);
        chk({extAddr, d}, 16'h503c);
        wr(6'h05, 8'hf1);
        #1 chk({cps, pinOut[3:0], pinDriveN}, 30'h3e000000);
        wr(6'h0c, 8'hff);
        rd(6'h0c);
        chk({run, d}, 12'hf0f);
        wr(6'h0a, 8'h05);
        wr(6'h0b, 8'hff);
        rd(6'h0b);
        chk(d, 8'h0f);
        wr(6'h09, 8'h80);
        #1 chk({lcdBiasSel, comOut}, 5'h10);
        // panel on: half duty, A wave, rate code 0; slot of 256 ticks, tick every 2 cycles
        wr(6'h09, 8'h10);
        repeat (100) @(posedge core_clk);
        #1 chk({comOut, segOut[5]}, 5'h03);
        repeat (300) @(posedge core_clk);
        #1 chk({comOut, segOut[5]}, 5'h1c);
        repeat (300) @(posedge core_clk);
        #1 chk({comOut, segOut[5]}, 5'h05);
        wr(6'h09, 8'h00);
        @(posedge core_clk);
        #1 chk({comOut, segOut}, 36'h0);
        // cycle counting: ff rolls over one edge after the read edge
        wr(6'h01, 8'hfd);
        rd(6'h01);
        chk(d, 8'hfe);
        @(posedge core_clk);
        #1 chk(timerWrap, 1'b1);
        // pin counting: three pulses, each seen after the two-stage sync
        tmrExt <= 1'b1;
        wr(6'h01, 8'h00);
        repeat (3) begin
            @(posedge core_clk);
            tmrPin <= 1'b1;
            repeat (2) @(posedge core_clk);
            tmrPin <= 1'b0;
        end
        rd(6'h01);
        chk(d, 8'h03);
        // pin reset after sleep keeps the cause flags, clears the rest
        go(5, 10'h000, 8'h00);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(6'h03);
        chk(d, 8'h10);
        chk(pcValue, 12'h000);
        finish_test();
    end
endmodule
`default_nettype wire
